/* File: verilog/drdt_timer.sv */
// dual 8-bit reload down timer with event counting on timer 0
`timescale 1ns/1ps
`include "drdt_regs.svh"

module drdt_timer (
    // clock and reset
    input  wire logic                     CLOCK,
    input  wire logic                     RST_N,
    // oscillator and event pins
    input  wire logic                     LOW_SPEED_OSC,
    input  wire logic                     HIGH_SPEED_OSC,
    input  wire logic                     EVENT_INPUT_PIN,
    // channel configuration
    input  wire drdt_pkg::drdt_chan_cfg_t  T0_CFG,
    input  wire drdt_pkg::drdt_chan_cfg_t  T1_CFG,
    input  wire drdt_pkg::drdt_event_cfg_t T0_EVENT_CFG,
    input  wire logic [7:0]               T0_RELOAD_VALUE,
    input  wire logic [7:0]               T1_RELOAD_VALUE,
    input  wire logic                     T0_PRESET_STROBE,
    input  wire logic                     T1_PRESET_STROBE,
    // counter readback
    input  wire drdt_pkg::drdt_read_t      T0_READ,
    input  wire drdt_pkg::drdt_read_t      T1_READ,
    output logic [7:0]                    T0_COUNT_READBACK,
    output logic [7:0]                    T1_COUNT_READBACK,
    // interrupt flags and masks
    input  wire logic                     T0_FLAG_CLEAR,
    input  wire logic                     T1_FLAG_CLEAR,
    input  wire logic                     T0_IRQ_MASK,
    input  wire logic                     T1_IRQ_MASK,
    output logic                          T0_UNDERFLOW_FLAG,
    output logic                          T1_UNDERFLOW_FLAG,
    output logic                          T0_IRQ,
    output logic                          T1_IRQ,
    // underflow pulses
    output logic                          T0_DIVIDED_PULSE_OUT,
    output logic                          T1_DIVIDED_PULSE_OUT,
    output logic                          SERIAL_CLK_TICK
);

    localparam int NCH = 2;
    localparam int NPIN = 3;
    localparam int PIN_LOW = 0;
    localparam int PIN_HIGH = 1;
    localparam int PIN_EVT = 2;

    // per-channel views of the ports
    drdt_pkg::drdt_chan_cfg_t cfg      [NCH];
    drdt_pkg::drdt_read_t     rd       [NCH];
    logic [7:0]               reload   [NCH];
    logic                     preset   [NCH];
    logic                     clr      [NCH];
    logic                     mask     [NCH];

    assign cfg[0]    = T0_CFG;
    assign cfg[1]    = T1_CFG;
    assign rd[0]     = T0_READ;
    assign rd[1]     = T1_READ;
    assign reload[0] = T0_RELOAD_VALUE;
    assign reload[1] = T1_RELOAD_VALUE;
    assign preset[0] = T0_PRESET_STROBE;
    assign preset[1] = T1_PRESET_STROBE;
    assign clr[0]    = T0_FLAG_CLEAR;
    assign clr[1]    = T1_FLAG_CLEAR;
    assign mask[0]   = T0_IRQ_MASK;
    assign mask[1]   = T1_IRQ_MASK;

    // three-stage synchronisers for the pins
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] level_reg;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] agree;

    assign pin_in = {EVENT_INPUT_PIN, HIGH_SPEED_OSC, LOW_SPEED_OSC};

    // the first stage is read only by the second
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_pin
            assign agree[p] = (sync2_reg[p] == sync3_reg[p]);
            assign rise[p]  = agree[p] & sync3_reg[p] & ~level_reg[p];
        end
    endgenerate

    // a change counts only once the second and third stages agree
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            level_reg <= '0;
        end else begin
            level_reg <= (agree & sync3_reg) | (~agree & level_reg);
        end
    end

    // 2048 Hz sampling signal from the low-speed oscillator
    logic [3:0] sample_div_reg;
    logic       sample_fall;

    // a falling point is the low-speed rise that wraps the divider
    assign sample_fall = rise[PIN_LOW] &&
                         (sample_div_reg == `DRDT_SAMPLE_FALL);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sample_div_reg <= `DRDT_SAMPLE_RESET;
        end else if (rise[PIN_LOW]) begin
            sample_div_reg <= sample_div_reg + `DRDT_SAMPLE_ONE;
        end
    end

    // noise rejector on the event input
    drdt_pkg::drdt_flt_state_t flt_state_reg;
    drdt_pkg::drdt_flt_state_t flt_state_next;
    logic                      flt_level_reg;
    logic                      flt_accept;
    logic                      raw_changed;

    // a change must survive two sampling falls; if it vanishes, restart
    assign raw_changed = (level_reg[PIN_EVT] != flt_level_reg);

    always_comb begin
        flt_state_next = flt_state_reg;
        flt_accept     = 1'b0;
        case (flt_state_reg)
            drdt_pkg::DRDT_FLT_STABLE: begin
                if (raw_changed) begin
                    flt_state_next = drdt_pkg::DRDT_FLT_WAIT1;
                end
            end
            drdt_pkg::DRDT_FLT_WAIT1: begin
                if (!raw_changed) begin
                    flt_state_next = drdt_pkg::DRDT_FLT_STABLE;
                end else if (sample_fall) begin
                    flt_state_next = drdt_pkg::DRDT_FLT_WAIT2;
                end
            end
            drdt_pkg::DRDT_FLT_WAIT2: begin
                if (!raw_changed) begin
                    flt_state_next = drdt_pkg::DRDT_FLT_STABLE;
                end else if (sample_fall) begin
                    flt_accept     = 1'b1;
                    flt_state_next = drdt_pkg::DRDT_FLT_STABLE;
                end
            end
            default: begin
                flt_state_next = drdt_pkg::DRDT_FLT_STABLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            flt_state_reg <= drdt_pkg::DRDT_FLT_STABLE;
        end else begin
            flt_state_reg <= flt_state_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            flt_level_reg <= 1'b0;
        end else if (flt_accept) begin
            // only an accepted change moves the filtered level
            flt_level_reg <= level_reg[PIN_EVT];
        end
    end

    // event edge selection
    logic evt_level;
    logic evt_prev_reg;
    logic evt_tick;

    assign evt_level = T0_EVENT_CFG.noise_filter_enable ? flt_level_reg
                                                       : level_reg[PIN_EVT];
    assign evt_tick = T0_EVENT_CFG.event_edge_polarity
                    ? (evt_level & ~evt_prev_reg)
                    : (~evt_level & evt_prev_reg);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            evt_prev_reg <= 1'b0;
        end else begin
            evt_prev_reg <= evt_level;
        end
    end

    // per-channel prescaler, counter, readback and flag
    logic       uflow         [NCH];
    logic       flag_q        [NCH];
    logic [7:0] readback_q    [NCH];
    logic       irq_q         [NCH];
    logic       uflow_pulse_w [NCH];

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [7:0] pre_reg;
            logic [7:0] pre_mask;
            logic [7:0] cnt_reg;
            logic [3:0] hold_hi_reg;
            logic       hold_reg;
            logic       src_edge;
            logic       pre_tick;
            logic       cnt_tick;
            logic       event_mode;
            logic       flag_reg;
            logic       irq_reg;
            logic       uflow_reg;
            logic [7:0] rb_reg;

            // timer 1 has no event path
            assign event_mode = (c == 0) &&
                                T0_EVENT_CFG.event_mode_sel;

            assign src_edge = cfg[c].source_sel ? rise[PIN_HIGH]
                                                : rise[PIN_LOW];

            always_comb begin
                case (cfg[c].divider_ratio)
                    `DRDT_RATIO_DIV4:   pre_mask = `DRDT_MASK_DIV4;
                    `DRDT_RATIO_DIV32:  pre_mask = `DRDT_MASK_DIV32;
                    `DRDT_RATIO_DIV256: pre_mask = `DRDT_MASK_DIV256;
                    default:            pre_mask = `DRDT_PRE_RESET;
                endcase
            end

            assign pre_tick = cfg[c].run_bit && src_edge &&
                              ((pre_reg & pre_mask) == pre_mask);

            // prescaler keeps its phase across stop and ratio changes
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    pre_reg <= `DRDT_PRE_RESET;
                end else if (cfg[c].run_bit && src_edge) begin
                    pre_reg <= pre_reg + `DRDT_PRE_ONE;
                end
            end

            assign cnt_tick = cfg[c].run_bit &&
                              (event_mode ? evt_tick : pre_tick);

            // a preset in the same cycle wins over the underflow
            assign uflow[c] = cnt_tick && !preset[c] &&
                              (cnt_reg == `DRDT_CNT_ZERO);

            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    cnt_reg <= `DRDT_CNT_RESET;
                end else if (preset[c]) begin
                    cnt_reg <= reload[c];
                end else if (uflow[c]) begin
                    cnt_reg <= reload[c];
                end else if (cnt_tick) begin
                    cnt_reg <= cnt_reg - `DRDT_CNT_ONE;
                end
            end

            // high nibble held from low read until high read
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    hold_reg    <= 1'b0;
                    hold_hi_reg <= `DRDT_NIB_RESET;
                end else if (rd[c].low_read) begin
                    hold_reg    <= 1'b1;
                    hold_hi_reg <= cnt_reg[`DRDT_HI_MSB:`DRDT_HI_LSB];
                end else if (rd[c].high_read) begin
                    hold_reg    <= 1'b0;
                end
            end

            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    rb_reg <= `DRDT_CNT_RESET;
                end else if (rd[c].low_read) begin
                    rb_reg <= cnt_reg;
                end else if (hold_reg) begin
                    // held high nibble over the live low nibble
                    rb_reg <= {hold_hi_reg,
                               cnt_reg[`DRDT_LO_MSB:`DRDT_LO_LSB]};
                end else begin
                    rb_reg <= cnt_reg;
                end
            end

            // set wins over a simultaneous clear
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    flag_reg <= 1'b0;
                end else if (uflow[c]) begin
                    flag_reg <= 1'b1;
                end else if (clr[c]) begin
                    flag_reg <= 1'b0;
                end
            end

            // irq trails a flag clear by one cycle
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    irq_reg   <= 1'b0;
                    uflow_reg <= 1'b0;
                end else begin
                    irq_reg   <= (flag_reg || uflow[c]) && mask[c];
                    uflow_reg <= uflow[c];
                end
            end

            assign flag_q[c]     = flag_reg;
            assign irq_q[c]      = irq_reg;
            assign readback_q[c] = rb_reg;
            assign uflow_pulse_w[c] = uflow_reg;
        end
    endgenerate

    // every output below is taken straight from a register
    assign T0_COUNT_READBACK    = readback_q[0];
    assign T1_COUNT_READBACK    = readback_q[1];
    assign T0_UNDERFLOW_FLAG    = flag_q[0];
    assign T1_UNDERFLOW_FLAG    = flag_q[1];
    assign T0_IRQ               = irq_q[0];
    assign T1_IRQ               = irq_q[1];
    assign T0_DIVIDED_PULSE_OUT = uflow_pulse_w[0];
    assign T1_DIVIDED_PULSE_OUT = uflow_pulse_w[1];
    assign SERIAL_CLK_TICK      = uflow_pulse_w[1];

endmodule

/* File: verilog/drdt_regs.svh */
// constants for the dual reload down timer
`ifndef DRDT_REGS_SVH
`define DRDT_REGS_SVH

`define DRDT_CNT_W          8
`define DRDT_NIB_W          4
`define DRDT_CNT_RESET      8'h00
`define DRDT_CNT_ZERO       8'h00
`define DRDT_CNT_ONE        8'h01
`define DRDT_PRE_RESET      8'h00
`define DRDT_PRE_ONE        8'h01
`define DRDT_RATIO_DIV1     2'h0
`define DRDT_RATIO_DIV4     2'h1
`define DRDT_RATIO_DIV32    2'h2
`define DRDT_RATIO_DIV256   2'h3
`define DRDT_MASK_DIV4      8'h03
`define DRDT_MASK_DIV32     8'h1F
`define DRDT_MASK_DIV256    8'hFF
`define DRDT_SAMPLE_RESET   4'h0
`define DRDT_SAMPLE_ONE     4'h1
`define DRDT_SAMPLE_FALL    4'hF
`define DRDT_NIB_RESET      4'h0
`define DRDT_HI_MSB         7
`define DRDT_HI_LSB         4
`define DRDT_LO_MSB         3
`define DRDT_LO_LSB         0

`endif

/* File: verilog/drdt_pkg.sv */
// types shared by the dual reload down timer
package drdt_pkg;

    typedef struct packed {
        logic       run_bit;
        logic       source_sel;
        logic [1:0] divider_ratio;
    } drdt_chan_cfg_t;

    typedef struct packed {
        logic event_mode_sel;
        logic event_edge_polarity;
        logic noise_filter_enable;
    } drdt_event_cfg_t;

    typedef struct packed {
        logic low_read;
        logic high_read;
    } drdt_read_t;

    typedef enum logic [1:0] {
        DRDT_FLT_STABLE = 2'h0,
        DRDT_FLT_WAIT1  = 2'h1,
        DRDT_FLT_WAIT2  = 2'h3
    } drdt_flt_state_t;

endpackage

/* File: sim/drdt_event_src.sv */
// behavioural source of pulses on the external event pin
`timescale 1ns/1ps
module drdt_event_src (
    // clock
    input  wire logic CLOCK,
    // event pin
    output logic      EVENT_INPUT_PIN
);
    initial EVENT_INPUT_PIN = 1'b0;

    // levels are held whole cycles, the caller picks widths the filter needs
    task automatic drive_level(input logic lvl);
        @(posedge CLOCK);
        EVENT_INPUT_PIN <= lvl;
    endtask

    task automatic pulse(input int n, input int width);
        repeat (n) begin
            drive_level(1'b1);
            repeat (width) @(posedge CLOCK);
            drive_level(1'b0);
            repeat (width) @(posedge CLOCK);
        end
    endtask
endmodule

/* File: sim/drdt_timer_sva.sv */
// assertion checker for the dual reload down timer
`timescale 1ns/1ps
module drdt_timer_sva (
    // clock and reset
    input wire logic                     CLOCK,
    input wire logic                     RST_N,
    // timer 0
    input wire drdt_pkg::drdt_chan_cfg_t T0_CFG,
    input wire logic [7:0]               T0_RELOAD_VALUE,
    input wire logic                     T0_PRESET_STROBE,
    input wire drdt_pkg::drdt_read_t     T0_READ,
    input wire logic [7:0]               T0_COUNT_READBACK,
    input wire logic                     T0_FLAG_CLEAR,
    input wire logic                     T0_IRQ_MASK,
    input wire logic                     T0_UNDERFLOW_FLAG,
    input wire logic                     T0_IRQ,
    input wire logic                     T0_DIVIDED_PULSE_OUT,
    // timer 1
    input wire logic                     T1_DIVIDED_PULSE_OUT,
    input wire logic                     SERIAL_CLK_TICK
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_serial_tick_copy: assert property (
        SERIAL_CLK_TICK == T1_DIVIDED_PULSE_OUT) else $error("serial tick");
    a_pulse_one_cycle: assert property (
        T0_DIVIDED_PULSE_OUT |=> !T0_DIVIDED_PULSE_OUT) else $error("pulse");
    a_flag_on_pulse: assert property (
        T0_DIVIDED_PULSE_OUT |-> T0_UNDERFLOW_FLAG) else $error("flag set");
    a_flag_clear_one: assert property (
        T0_FLAG_CLEAR |=> !T0_UNDERFLOW_FLAG || T0_DIVIDED_PULSE_OUT)
        else $error("flag clear");
    a_flag_stays_set: assert property (
        T0_UNDERFLOW_FLAG && !T0_FLAG_CLEAR |=> T0_UNDERFLOW_FLAG)
        else $error("flag lost");
    a_irq_when_enabled: assert property (
        T0_UNDERFLOW_FLAG && T0_IRQ_MASK |=> T0_IRQ) else $error("irq");
    a_irq_when_masked: assert property (
        !T0_IRQ_MASK |=> !T0_IRQ) else $error("irq masked");
    a_preset_loads: assert property (
        T0_PRESET_STROBE |-> ##2
            T0_COUNT_READBACK == $past(T0_RELOAD_VALUE, 2))
        else $error("preset");
    a_stop_holds: assert property (
        (!T0_CFG.run_bit && !T0_PRESET_STROBE && !T0_READ.high_read)[*4]
        |=> $stable(T0_COUNT_READBACK)) else $error("stop");

    c_irq: cover property (T0_DIVIDED_PULSE_OUT && T0_IRQ);
    c_serial: cover property (SERIAL_CLK_TICK);
    c_clear: cover property (T0_FLAG_CLEAR && T0_UNDERFLOW_FLAG);
endmodule

bind drdt_timer drdt_timer_sva u_sva (.CLOCK, .RST_N, .T0_CFG,
    .T0_RELOAD_VALUE, .T0_PRESET_STROBE, .T0_READ, .T0_COUNT_READBACK,
    .T0_FLAG_CLEAR, .T0_IRQ_MASK, .T0_UNDERFLOW_FLAG, .T0_IRQ,
    .T0_DIVIDED_PULSE_OUT, .T1_DIVIDED_PULSE_OUT, .SERIAL_CLK_TICK);

/* File: sim/drdt_timer_test.sv */
// self-checking bench for the dual reload down timer
`timescale 1ns/1ps
module drdt_timer_test;
    logic                      clock = 1'b0;
    logic                      rst_n = 1'b0;
    logic                      lo_osc = 1'b0, hi_osc = 1'b0;
    logic [2:0]                osc_div = 3'h0;
    wire logic                 ev_pin;
    drdt_pkg::drdt_chan_cfg_t  t0_cfg = '0, t1_cfg = '0;
    drdt_pkg::drdt_event_cfg_t ev_cfg = '0;
    drdt_pkg::drdt_read_t      t0_rd = '0, t1_rd = '0;
    logic                      ser_tick;
    logic [7:0]                t0_rl = 8'h00, t1_rl = 8'h00;
    logic [7:0]                t0_rb, t1_rb;
    logic                      t0_ps = 1'b0, t1_ps = 1'b0;
    logic                      t0_clr = 1'b0, t1_clr = 1'b0;
    logic                      t0_msk = 1'b0, t1_msk = 1'b0;
    logic                      t0_fl, t1_fl, t0_irq, t1_irq, t0_po, t1_po;
    int                        err_total = 0, n_tests = 0;

    always #5 clock = ~clock;

    // oscillators: high one has an 8-cycle period, low one 16
    always @(posedge clock) begin
        osc_div <= osc_div + 3'h1;
        if (osc_div[1:0] == 2'h3) hi_osc <= ~hi_osc;
        if (osc_div == 3'h7) lo_osc <= ~lo_osc;
    end

    drdt_event_src src (.CLOCK(clock), .EVENT_INPUT_PIN(ev_pin));

    drdt_timer dut (.CLOCK(clock), .RST_N(rst_n),
        .LOW_SPEED_OSC(lo_osc), .HIGH_SPEED_OSC(hi_osc),
        .EVENT_INPUT_PIN(ev_pin), .T0_CFG(t0_cfg), .T1_CFG(t1_cfg),
        .T0_EVENT_CFG(ev_cfg), .T0_RELOAD_VALUE(t0_rl),
        .T1_RELOAD_VALUE(t1_rl), .T0_PRESET_STROBE(t0_ps),
        .T1_PRESET_STROBE(t1_ps), .T0_READ(t0_rd), .T1_READ(t1_rd),
        .T0_COUNT_READBACK(t0_rb), .T1_COUNT_READBACK(t1_rb),
        .T0_FLAG_CLEAR(t0_clr), .T1_FLAG_CLEAR(t1_clr),
        .T0_IRQ_MASK(t0_msk), .T1_IRQ_MASK(t1_msk),
        .T0_UNDERFLOW_FLAG(t0_fl), .T1_UNDERFLOW_FLAG(t1_fl),
        .T0_IRQ(t0_irq), .T1_IRQ(t1_irq), .T0_DIVIDED_PULSE_OUT(t0_po),
        .T1_DIVIDED_PULSE_OUT(t1_po), .SERIAL_CLK_TICK(ser_tick));

    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic chkn(input string what, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
            err_total++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one-cycle pulse on a strobe selected by k
    task automatic strobe(input int k);
        @(posedge clock);
        case (k)
            0: t0_ps <= 1'b1;
            1: t1_ps <= 1'b1;
            2: t0_clr <= 1'b1;
            3: t1_clr <= 1'b1;
            4: t0_rd.low_read <= 1'b1;
            5: t0_rd.high_read <= 1'b1;
            6: t1_rd.low_read <= 1'b1;
            default: t1_rd.high_read <= 1'b1;
        endcase
        @(posedge clock);
        {t0_ps, t1_ps, t0_clr, t1_clr, t0_rd, t1_rd} <= '0;
    endtask

    task automatic wait_pulse(input bit ch, output int n);
        for (n = 1; n <= 20000; n++) begin
            @(negedge clock);
            if ((ch ? t1_po : t0_po) === 1'b1) return;
        end
        $display("mismatch underflow expected pulse seen none");
        err_total++;
        final_report();
    endtask

    // cycles between two underflows, after one to settle the phase
    task automatic period(input bit ch, input int exp);
        int n;
        wait_pulse(ch, n);
        wait_pulse(ch, n);
        chkn("period", exp, n);
        chk("serial", 8'(ch), {7'h00, ser_tick});
    endtask

    task automatic t_preset();
        @(posedge clock);
        t0_rl <= 8'h5A;
        t1_rl <= 8'hA5;
        strobe(0);
        strobe(1);
        cyc(2);
        chk("t0_count", 8'h5A, t0_rb);
        chk("t1_count", 8'hA5, t1_rb);
        strobe(6);
        @(posedge clock);
        t1_rl <= 8'h5A;
        strobe(1);
        cyc(2);
        chk("t1_held", 8'hAA, t1_rb);
        strobe(7);
        cyc(2);
        chk("t1_live", 8'h5A, t1_rb);
    endtask

    task automatic t_ratio();
        int div[4] = '{1, 4, 32, 256};
        @(posedge clock);
        t0_rl <= 8'h01;
        strobe(0);
        for (int r = 0; r < 4; r++) begin
            @(posedge clock);
            t0_cfg <= '{1'b1, 1'b0, 2'(r)};
            period(0, 2 * div[r] * 16);
        end
        @(posedge clock);
        t0_cfg <= '0;
        t1_rl <= 8'h03;
        t1_cfg <= '{1'b1, 1'b1, 2'h1};
        strobe(1);
        period(1, 4 * 4 * 8);
        @(posedge clock);
        t1_cfg.run_bit <= 1'b0;
        t1_msk <= 1'b1;
        cyc(3);
        chk("t1_irq", 8'h01, 8'(t1_irq));
        strobe(3);
        cyc(2);
        chk("t1_flag", 8'h00, 8'(t1_fl));
    endtask

    task automatic t_stop_and_read();
        logic [7:0] v;
        logic [3:0] h;
        @(posedge clock);
        t0_rl <= 8'hFF;
        t0_cfg <= '{1'b1, 1'b0, 2'h0};
        strobe(0);
        cyc(100);
        @(posedge clock);
        t0_cfg.run_bit <= 1'b0;
        cyc(5);
        v = t0_rb;
        cyc(100);
        chk("stopped", v, t0_rb);
        @(posedge clock);
        t0_cfg.run_bit <= 1'b1;
        cyc(40);
        chk("resumed", 8'h01, 8'(t0_rb < v));
        strobe(4);
        cyc(1);
        h = t0_rb[7:4];
        cyc(300);
        chk("held_high", 8'(h), 8'(t0_rb[7:4]));
        strobe(5);
        cyc(2);
        chk("released", 8'h01, 8'(t0_rb[7:4] !== h));
    endtask

    task automatic t_flags();
        int n;
        @(posedge clock);
        t0_rl <= 8'h00;
        strobe(0);
        strobe(2);
        wait_pulse(0, n);
        chk("t0_flag", 8'h01, 8'(t0_fl));
        chk("t0_irq", 8'h00, 8'(t0_irq));
        @(posedge clock);
        t0_cfg.run_bit <= 1'b0;
        t0_msk <= 1'b1;
        cyc(3);
        chk("t0_irq", 8'h01, 8'(t0_irq));
        strobe(2);
        cyc(2);
        chk("t0_clear", 8'h00, {7'h00, t0_fl | t0_irq});
    endtask

    task automatic t_event();
        @(posedge clock);
        t0_rl <= 8'h02;
        t0_cfg <= '{1'b1, 1'b1, 2'h3};
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            ev_cfg <= '{1'b1, 1'(p), 1'b0};
            strobe(0);
            strobe(2);
            src.pulse(2, 10);
            cyc(10);
            chk("ev_two", 8'h00, 8'(t0_fl));
            src.drive_level(1'b1);
            cyc(12);
            chk("ev_rise", 8'(p), 8'(t0_fl));
            src.drive_level(1'b0);
            cyc(12);
            chk("ev_fall", 8'h01, 8'(t0_fl));
        end
    endtask

    task automatic t_filter();
        @(posedge clock);
        t0_rl <= 8'h00;
        ev_cfg <= '{1'b1, 1'b1, 1'b1};
        strobe(0);
        strobe(2);
        src.pulse(1, 20);
        cyc(600);
        chk("glitch", 8'h00, 8'(t0_fl));
        src.drive_level(1'b1);
        cyc(250);
        chk("filt_early", 8'h00, 8'(t0_fl));
        cyc(280);
        chk("filt_late", 8'h01, 8'(t0_fl));
        src.drive_level(1'b0);
        cyc(600);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        cyc(2);
        chk("idle", 8'h00, {t0_fl, t1_fl, t0_irq, t1_irq, 4'h0});
        t_preset();
        t_ratio();
        t_stop_and_read();
        t_flags();
        t_event();
        t_filter();
        final_report();
    end
endmodule
